// *** core/pwmdc_pkg.sv ***
// pwm duty compare package: register map, field layout, modes, helpers
// assumes a 200 MHz hclk, one hclk per oscillator phase
package pwmdc_pkg;
  localparam int DUTY_W   = 14;
  localparam int CNT_W    = 12;
  localparam int NUM_CH   = 3;
  localparam int HI_W     = 6;
  localparam int CLK_NS   = 5;
  localparam int UPDN_MUL = 2;
  localparam int PH_COUNT = 4;
  localparam int PER_W    = 24;

  localparam logic [7:0] OFS_DUTY_BASE = 8'h00;
  localparam logic [7:0] DUTY_STRIDE   = 8'h08;
  localparam logic [7:0] OFS_HI_STEP   = 8'h04;
  localparam logic [7:0] OFS_CTRL      = 8'h18;
  localparam logic [7:0] OFS_STAT      = 8'h1c;
  localparam logic [7:0] OFS_PERIOD    = 8'h20;

  localparam logic [2:0]        CTRL_RST = 3'h7;
  localparam logic [7:0]        LO_RST   = 8'h00;
  localparam logic [HI_W-1:0]   HI_RST   = 6'h00;
  localparam logic [DUTY_W-1:0] DUTY_RST = 14'h0000;

  localparam int STAT_DOWN = 0;
  localparam int STAT_RUN  = 1;
  localparam int STAT_MODE = 2;
  localparam int STAT_PS   = 4;
  localparam int STAT_OUT  = 8;

  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_ONE  = 2'h1;
  localparam logic [1:0] MODE_UPDN = 2'h2;
  localparam logic [1:0] MODE_DBL  = 2'h3;
  localparam logic [1:0] PS_1TO1   = 2'h0;
  localparam logic [1:0] PH_ONE    = 2'h0;
  localparam logic [1:0] PH_FOUR   = 2'h3;
  localparam logic [1:0] HTRANS_NS = 2'h2;
  localparam logic [2:0] HSIZE_W32 = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_RUN  = 3'b100
  } pwmdc_state_e;

  function automatic logic is_updown(input logic [1:0] mode);
    return mode[1];
  endfunction

  function automatic logic [6:0] ps_ratio(input logic [1:0] sel);
    return 7'(7'h01 << {sel, 1'b0});
  endfunction

  // period in hclk cycles, four phases times the prescale ratio per count step
  function automatic logic [PER_W-1:0] pwm_period(
      input logic [CNT_W-1:0] per, input logic [1:0] sel, input logic ud);
    logic [PER_W-1:0] base;
    base = ud ? PER_W'(UPDN_MUL * per) : PER_W'(per) + PER_W'(1);
    return PER_W'(base * ps_ratio(sel) * PH_COUNT);
  endfunction
endpackage

// *** core/pwmdc_top.sv ***
// duty compare and output stage with an ahb-lite register slave
// assumes the time base drives count, direction, mode, run and phase
// synchronously to hclk and holds each count for at least one phase
//
// Summary of operation
// - up/down period is twice limit times prescale
// - three 14-bit duties from high and low bytes
// - upper twelve duty bits compare with count
// - edge match needs count and phase equal
// - coarse prescale matches on phase one
// - pairs forced complementary in complementary operation
// - buffer register plus separate active compare register
// - edge modes reload active duty at counter reset
// - stopped time base copies buffers continuously
// - up/down reloads when count zero turns upward
// - double update reloads at zero and limit
// - edge output active at zero, inactive on match
// - edge duty zero inactive, above limit active
// - center output set down, cleared up on match
// - center duty zero inactive, at limit active
// - center start begins counting down from limit
// - unit n drives odd main, even complement
// - mode field selects free, single, updown, double
// - direction flag read-only, set counting down
// - pairs reset to complementary operation
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module pwmdc_top
  import pwmdc_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [CNT_W-1:0]  time_base_count,
  input  wire logic [CNT_W-1:0]  period_limit,
  input  wire logic              count_down_flag,
  input  wire logic [1:0]        time_base_mode_sel,
  input  wire logic              time_base_run,
  input  wire logic [1:0]        time_base_prescale_sel,
  input  wire logic [1:0]        clock_phase,
  output logic                   out_pair0_low,
  output logic                   out_pair0_high,
  output logic                   out_pair1_low,
  output logic                   out_pair1_high,
  output logic                   out_pair2_low,
  output logic                   out_pair2_high
);
  logic [7:0]        addr_q;
  logic              wr_q;
  logic              rd_q;
  logic              take;
  logic [7:0]        dlo_q   [NUM_CH];
  logic [HI_W-1:0]   dhi_q   [NUM_CH];
  logic [DUTY_W-1:0] dbuf    [NUM_CH];
  logic [DUTY_W-1:0] act_q   [NUM_CH];
  logic [DUTY_W-1:0] duty_d  [NUM_CH];
  logic [NUM_CH-1:0] main;
  logic [NUM_CH-1:0] high_q;
  logic [NUM_CH-1:0] low_q;
  logic [2:0]        comp_q;
  logic [PER_W-1:0]  per_q;
  logic [CNT_W-1:0]  cnt_prev_q;
  logic              run_q;
  logic              armed_q;
  logic              new_count;
  logic              ph1_first;
  logic              updn;
  logic              fine;
  logic              ev_zero;
  logic              ev_per;
  logic              load;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (a == 8'(OFS_DUTY_BASE + DUTY_STRIDE * i))
        w = {24'h000000, dlo_q[i]};
      if (a == 8'(OFS_DUTY_BASE + DUTY_STRIDE * i + OFS_HI_STEP))
        w = {26'h0000000, dhi_q[i]};
    end
    if (a == OFS_CTRL) w = {29'h00000000, comp_q};
    if (a == OFS_STAT) begin
      w[STAT_DOWN]          = count_down_flag;
      w[STAT_RUN]           = time_base_run;
      w[STAT_MODE +: 2]     = time_base_mode_sel;
      w[STAT_PS +: 2]       = time_base_prescale_sel;
      w[STAT_OUT +: NUM_CH] = high_q;
      w[STAT_OUT + 4 +: NUM_CH] = low_q;
    end
    if (a == OFS_PERIOD) w = {8'h00, per_q};
    return w;
  endfunction

  // zero wait state slave; unmapped offsets read zero, writes dropped
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel && hready && htrans == HTRANS_NS
                     && hsize == HSIZE_W32;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q   <= take && hwrite;
      rd_q   <= take && !hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // read data is a mux of flops in the data phase, so a read right
  // after a write to the same word already sees the new value
  assign hrdata = rd_q ? rd_word(addr_q) : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dlo_q[i] <= LO_RST;
        dhi_q[i] <= HI_RST;
      end
    end else if (wr_q) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (addr_q == 8'(OFS_DUTY_BASE + DUTY_STRIDE * i))
          dlo_q[i] <= hwdata[7:0];
        if (addr_q == 8'(OFS_DUTY_BASE + DUTY_STRIDE * i + OFS_HI_STEP))
          dhi_q[i] <= hwdata[HI_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_q <= CTRL_RST;
    end else if (wr_q && addr_q == OFS_CTRL) begin
      comp_q <= hwdata[2:0];
    end
  end

  // time base inputs are only observed here
  assign updn = is_updown(time_base_mode_sel);
  assign fine = time_base_prescale_sel == PS_1TO1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_q <= '0;
    end else begin
      per_q <= pwm_period(period_limit, time_base_prescale_sel,
                          updn);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_prev_q <= '0;
      run_q      <= 1'b0;
    end else begin
      cnt_prev_q <= time_base_count;
      run_q      <= time_base_run;
    end
  end

  // a count seen before its phase one is remembered until that phase
  assign new_count = time_base_run
                     && (time_base_count != cnt_prev_q || !run_q);
  assign ph1_first = clock_phase == PH_ONE && (new_count || armed_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_q <= 1'b0;
    end else if (!time_base_run || clock_phase == PH_ONE) begin
      armed_q <= 1'b0;
    end else if (new_count) begin
      armed_q <= 1'b1;
    end
  end

  assign ev_zero = ph1_first && time_base_count == '0;
  assign ev_per  = ph1_first && time_base_count == period_limit;
  assign load    = !time_base_run
                   || (!updn && ev_zero)
                   || (updn && ev_zero)
                   || (time_base_mode_sel == MODE_DBL && ev_per);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign dbuf[g]   = {dhi_q[g], dlo_q[g]};
    // the compare sees the reloaded value in the reload cycle itself
    assign duty_d[g] = load ? dbuf[g] : act_q[g];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        act_q[g] <= DUTY_RST;
      end else begin
        act_q[g] <= duty_d[g];
      end
    end

    pwmdc_unit u_unit (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .duty     (duty_d[g]),
      .count    (time_base_count),
      .period   (period_limit),
      .down     (count_down_flag),
      .run      (time_base_run),
      .center   (updn),
      .fine     (fine),
      .phase    (clock_phase),
      .ph1_first (ph1_first),
      .main_q   (main[g])
    );

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        high_q[g] <= 1'b0;
        low_q[g]  <= 1'b1;
      end else begin
        high_q[g] <= main[g];
        low_q[g]  <= comp_q[g] ? !main[g] : main[g];
      end
    end
  end

  assign out_pair0_high = high_q[0];
  assign out_pair0_low  = low_q[0];
  assign out_pair1_high = high_q[1];
  assign out_pair1_low  = low_q[1];
  assign out_pair2_high = high_q[2];
  assign out_pair2_low  = low_q[2];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_write(logic [7:0] ofs);
    take && hwrite && haddr[7:0] == ofs;
  endsequence

  property p_lo_write;
    logic [7:0] v;
    (s_write(OFS_DUTY_BASE), v = hwdata[7:0]) ##1 (1, v = hwdata[7:0])
      |=> dlo_q[0] == v;
  endproperty
  a_lo_write: assert property (p_lo_write)
    else $error("duty low byte not stored");

  property p_stopped_copy;
    !time_base_run |=> act_q[0] == $past(dbuf[0]);
  endproperty
  a_stopped_copy: assert property (p_stopped_copy)
    else $error("active duty not copied while stopped");

  property p_hold;
    time_base_run && !ev_zero && !ev_per |=> act_q[1] == $past(act_q[1]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("active duty changed mid period");

  property p_dbl;
    time_base_run && time_base_mode_sel == MODE_DBL && ev_per
      |=> act_q[2] == $past(dbuf[2]);
  endproperty
  a_dbl: assert property (p_dbl)
    else $error("double update missed at limit");

  property p_comp;
    comp_q[0] |=> low_q[0] == !high_q[0];
  endproperty
  a_comp: assert property (p_comp)
    else $error("pair 0 outputs not complementary");

  property p_map;
    ##1 out_pair1_high == $past(main[1]);
  endproperty
  a_map: assert property (p_map)
    else $error("unit 1 not on pair 1 main output");

  // per_q lags one cycle, so the inputs must hold across that cycle
  property p_period;
    updn ##1 updn && $stable(period_limit)
      && $stable(time_base_prescale_sel)
      |-> per_q == PER_W'(UPDN_MUL * period_limit
        * ps_ratio(time_base_prescale_sel) * PH_COUNT);
  endproperty
  a_period: assert property (p_period)
    else $error("up/down period figure wrong");

  property p_status_dir;
    rd_q && addr_q == OFS_STAT |-> hrdata[STAT_DOWN] == count_down_flag;
  endproperty
  a_status_dir: assert property (p_status_dir)
    else $error("direction flag not shown in status");

  property p_stat_out;
    rd_q && addr_q == OFS_STAT |-> hrdata[STAT_OUT +: NUM_CH]
      == {out_pair2_high, out_pair1_high, out_pair0_high};
  endproperty
  a_stat_out: assert property (p_stat_out)
    else $error("status does not show the main outputs");

  sequence s_zero_start;
    time_base_run && ev_zero;
  endsequence

  property p_edge_reload;
    s_zero_start ##0 !updn |=> act_q[1] == $past(dbuf[1]);
  endproperty
  a_edge_reload: assert property (p_edge_reload)
    else $error("edge mode active duty not reloaded at zero");

  property p_updn_reload;
    s_zero_start ##0 updn |=> act_q[0] == $past(dbuf[0]);
  endproperty
  a_updn_reload: assert property (p_updn_reload)
    else $error("up/down active duty not reloaded at zero");

  property p_indep;
    !comp_q[1] |=> low_q[1] == high_q[1];
  endproperty
  a_indep: assert property (p_indep)
    else $error("pair 1 low output not a copy in independent mode");

  property p_ctrl_write;
    s_write(OFS_CTRL) ##1 1'b1 |=> comp_q == $past(hwdata[2:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("complementary enables not stored");

  // a new count seen on phase one must start its step at once
  property p_step_phase;
    time_base_run && $changed(time_base_count) && clock_phase == PH_ONE
      |-> ph1_first;
  endproperty
  a_step_phase: assert property (p_step_phase)
    else $error("count step at phase one not flagged");
endmodule

// *** core/pwmdc_unit.sv ***
// one duty compare unit: match detection and main output level
// assumes duty, count and phase are stable and synchronous to hclk
`timescale 1ns/1ps
module pwmdc_unit
  import pwmdc_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic [DUTY_W-1:0] duty,
  input  wire logic [CNT_W-1:0]  count,
  input  wire logic [CNT_W-1:0]  period,
  input  wire logic              down,
  input  wire logic              run,
  input  wire logic              center,
  input  wire logic              fine,
  input  wire logic [1:0]        phase,
  input  wire logic              ph1_first,
  output logic                   main_q
);
  pwmdc_state_e     st_q;
  logic [CNT_W-1:0] up;
  logic             cnt_eq;
  logic             match;
  logic             start;
  logic             live;

  assign up     = duty[DUTY_W-1:2];
  assign cnt_eq = (count == up);
  // coarse prescale drops the phase bits and waits for phase one
  assign match  = fine ? (cnt_eq && phase == duty[1:0])
                       : (cnt_eq && ph1_first);
  assign start  = ph1_first && count == '0;
  // the first step of a run must already count, or a period start is lost;
  // a center run only waits while it still counts up
  assign live   = run && (st_q == ST_RUN || !center || down);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: if (run) st_q <= center ? ST_ARM : ST_RUN;
        // center start waits for the first down count from the limit
        ST_ARM:  if (!run) st_q <= ST_IDLE;
                 else if (down) st_q <= ST_RUN;
        ST_RUN:  if (!run) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_q <= 1'b0;
    end else if (!live) begin
      main_q <= 1'b0;
    end else if (center) begin
      if (duty == '0) main_q <= 1'b0;
      else if (up >= period) main_q <= 1'b1;
      else if (match) main_q <= down;
    end else begin
      if (up > period) main_q <= 1'b1;
      else if (match) main_q <= 1'b0;
      else if (start && duty != '0) main_q <= 1'b1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_center_run;
    st_q == ST_RUN && center && run;
  endsequence

  property p_center_zero;
    s_center_run ##0 duty == '0 |=> !main_q;
  endproperty
  a_center_zero: assert property (p_center_zero)
    else $error("center output active with zero duty");

  property p_center_set;
    s_center_run ##0 (match && down && duty != '0 && up < period)
      |=> main_q;
  endproperty
  a_center_set: assert property (p_center_set)
    else $error("center output not set on down match");

  property p_edge_clear;
    st_q == ST_RUN && run && !center && match && up <= period
      |=> !main_q;
  endproperty
  a_edge_clear: assert property (p_edge_clear)
    else $error("edge output not cleared on match");
endmodule

// *** tb/pwm_duty_compare_outputs_test.sv ***
// bench: ahb-lite master, time base driver, pulse width checks
// assumes pwmdc_bridge counts on-time on the pin pairs
`timescale 1ns/1ps
module pwm_duty_compare_outputs_test;
  import pwmdc_pkg::*;
  logic                    hclk    = 1'b0;
  logic                    hresetn = 1'b0;
  logic                    hsel    = 1'b0;
  logic [31:0]             haddr   = 32'h0;
  logic [1:0]              htrans  = 2'h0;
  logic                    hwrite  = 1'b0;
  logic [2:0]              hsize   = HSIZE_W32;
  logic [31:0]             hwdata  = 32'h0;
  logic [31:0]             hrdata;
  logic                    hreadyout;
  logic                    hresp;
  logic [CNT_W-1:0]        cnt     = 12'h000;
  logic [CNT_W-1:0]        lim     = 12'h004;
  logic                    down    = 1'b0;
  logic                    run     = 1'b0;
  logic [1:0]              mode    = MODE_FREE;
  logic [1:0]              sel     = PS_1TO1;
  logic [1:0]              ph      = PH_ONE;
  logic                    clr     = 1'b1;
  logic [NUM_CH-1:0]       hi;
  logic [NUM_CH-1:0]       lo;
  logic [NUM_CH-1:0][15:0] on_cnt;
  logic [15:0]             bad;
  int                      failures = 0;
  int                      n_tests  = 0;

  initial forever #2.5 hclk = ~hclk;

  pwmdc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .time_base_count(cnt),
    .period_limit(lim), .count_down_flag(down), .time_base_mode_sel(mode),
    .time_base_run(run), .time_base_prescale_sel(sel), .clock_phase(ph),
    .out_pair0_low(lo[0]), .out_pair0_high(hi[0]), .out_pair1_low(lo[1]),
    .out_pair1_high(hi[1]), .out_pair2_low(lo[2]), .out_pair2_high(hi[2]));

  pwmdc_bridge i_bridge (.hclk(hclk), .clr(clr), .hi(hi), .lo(lo),
    .on_cnt(on_cnt), .bad(bad));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // inputs only move at the rising edge, so what stands at the falling
  // edge is what the rising edge samples; avoids racing the data flops
  task automatic wait_rdy(output logic [31:0] d);
    logic rdy;
    d = 32'h0;
    for (int i = 0; i < 20; i++) begin
      @(negedge hclk);
      d   = hrdata;
      rdy = hreadyout;
      @(posedge hclk);
      if (rdy === 1'b1) return;
    end
    failures++;
    summarize();
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    logic [31:0] skip;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NS;
    hwrite <= wr;
    wait_rdy(skip);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(r, exp);
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic set_duty(input int ch, input logic [13:0] v);
    logic [31:0] r;
    logic [7:0]  a;
    a = OFS_DUTY_BASE + 8'(ch) * DUTY_STRIDE;
    ahb(1'b1, a, {24'h0, v[7:0]}, r);
    ahb(1'b1, a + OFS_HI_STEP, {26'h0, v[13:8]}, r);
  endtask

  // one count step: every phase of it at the current prescale
  task automatic hold(input int c, input logic d);
    for (int i = 0; i < (PH_COUNT << (2 * sel)); i++) begin
      @(posedge hclk);
      cnt <= c[CNT_W-1:0];
      down <= d;
      ph <= i[1:0];
      run <= 1'b1;
    end
  endtask

  // center sweeps start at the limit counting down, as the time base does
  task automatic sweep(input logic ctr);
    if (ctr) begin
      for (int c = lim; c > 0; c--) hold(c, 1'b1);
      for (int c = 0; c < lim; c++) hold(c, 1'b0);
    end else begin
      for (int c = 0; c <= lim; c++) hold(c, 1'b0);
    end
  endtask

  task automatic start(input logic [1:0] m, input logic [1:0] s);
    @(posedge hclk);
    mode <= m;
    sel <= s;
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
  endtask

  task automatic stop();
    @(posedge hclk);
    run <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  task automatic run_case(input logic [1:0] m, input logic [1:0] s,
      input int e0, input int e1, input int e2);
    int per;
    start(m, s);
    sweep(m[1]);
    stop();
    check(on_cnt[0], e0);
    check(on_cnt[1], e1);
    check(on_cnt[2], e2);
    check(bad, 32'h0);
    per = (m[1] ? 2 * lim : lim + 1) * (PH_COUNT << (2 * s));
    rd_chk(OFS_PERIOD, 32'(per));
    rd_chk(OFS_STAT, {17'h0, 3'h7, 6'h0, s, m, 2'h0});
  endtask

  task automatic after_reset();
    logic [31:0] r;
    check({29'h0, hi}, 32'h0);
    check({29'h0, lo}, 32'h7);
    for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
    rd_chk(OFS_CTRL, {29'h0, CTRL_RST});
    rd_chk(8'h24, 32'h0);
    ahb(1'b1, OFS_DUTY_BASE + OFS_HI_STEP, 32'hffffffff, r);
    rd_chk(OFS_DUTY_BASE + OFS_HI_STEP, 32'h3f);
    ahb(1'b1, OFS_DUTY_BASE, 32'hffffffff, r);
    rd_chk(OFS_DUTY_BASE, 32'hff);
    ahb(1'b1, OFS_CTRL, 32'h0, r);
    rd_chk(OFS_STAT, 32'h0);
    ahb(1'b1, OFS_CTRL, 32'h7, r);
  endtask

  // a write landing mid-period must wait for the next counter reset
  task automatic buffered();
    logic [31:0] r;
    set_duty(0, 14'h0008);
    start(MODE_FREE, PS_1TO1);
    fork
      begin
        sweep(1'b0);
        sweep(1'b0);
      end
      begin
        repeat (3) @(posedge hclk);
        ahb(1'b1, OFS_DUTY_BASE, 32'h0c, r);
      end
    join
    stop();
    check(on_cnt[0], 32'd20);
  endtask

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    after_reset();
    set_duty(0, 14'h000b);
    set_duty(1, 14'h0000);
    set_duty(2, 14'h0014);
    run_case(MODE_FREE, PS_1TO1, 11, 0, 20);
    run_case(MODE_ONE, 2'h1, 32, 0, 80);
    run_case(MODE_FREE, 2'h2, 128, 0, 320);
    // count two scaled by four, phase bits zero
    set_duty(0, 14'h0008);
    set_duty(2, 14'h0010);
    run_case(MODE_UPDN, PS_1TO1, 16, 0, 32);
    run_case(MODE_DBL, PS_1TO1, 16, 0, 32);
    run_case(MODE_UPDN, 2'h3, 1024, 0, 2048);
    buffered();
    summarize();
  end
endmodule

// *** tb/pwmdc_bridge.sv ***
// half-bridge switch model: on-time of each upper switch, pair faults
// assumes pwmdc_top drives the three pin pairs in complementary operation
`timescale 1ns/1ps
module pwmdc_bridge
  import pwmdc_pkg::*;
(
  input  wire logic                    hclk,
  input  wire logic                    clr,
  input  wire logic [NUM_CH-1:0]       hi,
  input  wire logic [NUM_CH-1:0]       lo,
  output logic      [NUM_CH-1:0][15:0] on_cnt,
  output logic      [15:0]             bad
);
  // both on shorts the rail, both off leaves the phase floating
  always_ff @(posedge hclk) begin
    if (clr) begin
      on_cnt <= '0;
      bad    <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hi[i] === 1'b1) on_cnt[i] <= on_cnt[i] + 16'h1;
        if (hi[i] !== ~lo[i]) bad <= bad + 16'h1;
      end
    end
  end
endmodule
